/* include/wid_consts.vh */
// constants for the wake and interrupt dispatch block
`ifndef WID_CONSTS_VH
`define WID_CONSTS_VH

// vector addresses handed to the core sequencer
`define WID_VEC_WIDTH 8
`define WID_VEC_COMPARATOR 8'h0F
`define WID_VEC_HIGH_PULSE 8'h12
`define WID_VEC_LOW_PULSE 8'h15
`define WID_VEC_AUX_A 8'h18
`define WID_VEC_AUX_B 8'h1B
`define WID_VEC_AUX_C 8'h1E
`define WID_RESET_ADDR 8'h00

// bit positions of the enables in their software banks
`define WID_POS_CMP_WAKE 2
`define WID_POS_CMP_IRQ 4
`define WID_POS_AUX_A 3
`define WID_POS_AUX_B 4
`define WID_POS_AUX_C 5
`define WID_POS_HIGH_PULSE 6
`define WID_POS_LOW_PULSE 7
`define WID_POS_WATCHDOG_ON 7

// reset values
`define WID_IRQ_ENABLED_RST 1'b0
`define WID_FLAG_RST 1'b0

`endif

/* verilog/wid_pending_flag.v */
// one sticky pending flag: hardware sets, software clears
`timescale 1ns/10ps
`include "wid_consts.vh"

module wid_pending_flag (
  mclk,
  nrst,
  setPulse,
  clearPulse,
  flag
);
  input wire mclk;
  input wire nrst;
  input wire setPulse; // event qualified by its enable
  input wire clearPulse; // software or reset-request clear
  output wire flag;

  reg flag_reg; // the stored flag
  reg flag_next; // its next value

  // ************************************************
  // set and clear
  // ************************************************
  // a set in the cycle of a clear wins, so no event is lost
  always @* begin
    if (setPulse) begin
      flag_next = 1'b1;
    end else if (clearPulse) begin
      flag_next = 1'b0;
    end else begin
      flag_next = flag_reg; // sticky until cleared
    end
  end

  // state register
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      flag_reg <= `WID_FLAG_RST;
    end else begin
      flag_reg <= flag_next;
    end
  end

  assign flag = flag_reg;
endmodule

/* verilog/wake_interrupt_dispatch.v */
// wake-up and interrupt dispatch for comparator, pulse timers, aux timers, watchdog
//
// Overview of operation
// - sleep, no enables: comparator change ignored
// - sleep, irq only: flag set, no wake
// - sleep, wake only: wake, next instruction, no flag
// - both enables, masked: wake, flag, next instruction
// - both enables, unmasked: flag, vector 00FH
// - sleeping: oscillator, timers, pulse unit stay stopped
// - normal, irq enable clear: no comparator interrupt
// - masked high-pulse underflow: flag, next instruction
// - unmasked high-pulse underflow: flag, vector 012H
// - masked low-pulse underflow: flag, next instruction
// - unmasked low-pulse underflow: flag, vector 015H
// - masked timer A overflow: flag, next instruction
// - unmasked timer A overflow: flag, vector 018H
// - masked timer B overflow: flag, next instruction
// - unmasked timer B overflow: flag, vector 01BH
// - masked timer C overflow: flag, next instruction
// - unmasked timer C overflow: flag, vector 01EH
// - enabled watchdog timeout: reset to 0x00, wake if asleep
`timescale 1ns/10ps
`include "wid_consts.vh"

module wake_interrupt_dispatch (
  mclk,
  nrst,
  sleepMode,
  globalIrqMaskOp,
  globalIrqUnmaskOp,
  comparatorWakeEnable,
  comparatorIrqEnable,
  highPulseUnderflowEnable,
  lowPulseUnderflowEnable,
  auxTimerAIrqEnable,
  auxTimerBIrqEnable,
  auxTimerCIrqEnable,
  watchdogOn,
  comparatorOut,
  highPulseUnderflow,
  lowPulseUnderflow,
  auxTimerAOverflow,
  auxTimerBOverflow,
  auxTimerCOverflow,
  watchdogTimeout,
  comparatorFlagClear,
  highPulseFlagClear,
  lowPulseFlagClear,
  auxTimerAFlagClear,
  auxTimerBFlagClear,
  auxTimerCFlagClear,
  comparatorPendingFlag,
  highPulseUnderflowFlag,
  lowPulseUnderflowFlag,
  auxTimerAOverflowFlag,
  auxTimerBOverflowFlag,
  auxTimerCOverflowFlag,
  irqEnabled,
  wakeReq,
  resumeNext,
  vectorReq,
  vectorAddr,
  watchdogResetReq,
  peripheralHalt
);
  // ************************************************
  // ports
  // ************************************************
  input wire mclk; // 10 MHz system clock
  input wire nrst; // asynchronous reset, active low
  input wire sleepMode; // core is asleep
  input wire globalIrqMaskOp; // pulse: core executed mask op
  input wire globalIrqUnmaskOp; // pulse: core executed unmask op
  input wire comparatorWakeEnable; // wake on comparator change
  input wire comparatorIrqEnable; // comparator interrupt enable
  input wire highPulseUnderflowEnable;
  input wire lowPulseUnderflowEnable;
  input wire auxTimerAIrqEnable;
  input wire auxTimerBIrqEnable;
  input wire auxTimerCIrqEnable;
  input wire watchdogOn; // watchdog enable
  input wire comparatorOut; // analog comparator, asynchronous
  input wire highPulseUnderflow; // pulses from same-clock logic
  input wire lowPulseUnderflow;
  input wire auxTimerAOverflow;
  input wire auxTimerBOverflow;
  input wire auxTimerCOverflow;
  input wire watchdogTimeout;
  input wire comparatorFlagClear; // software clear pulses
  input wire highPulseFlagClear;
  input wire lowPulseFlagClear;
  input wire auxTimerAFlagClear;
  input wire auxTimerBFlagClear;
  input wire auxTimerCFlagClear;
  output wire comparatorPendingFlag;
  output wire highPulseUnderflowFlag;
  output wire lowPulseUnderflowFlag;
  output wire auxTimerAOverflowFlag;
  output wire auxTimerBOverflowFlag;
  output wire auxTimerCOverflowFlag;
  output wire irqEnabled; // global interrupt state
  output wire wakeReq; // pulse: leave sleep
  output wire resumeNext; // pulse: woken, go on with next instruction
  output wire vectorReq; // pulse: branch to vectorAddr
  output wire [`WID_VEC_WIDTH-1:0] vectorAddr; // held until next request
  output wire watchdogResetReq; // pulse: reset core to resetAddr
  output wire peripheralHalt; // oscillator and timers stopped

  // ************************************************
  // declarations
  // ************************************************
  reg cmpSync1_reg; // first synchroniser stage
  reg cmpSync2_reg; // second synchroniser stage
  reg cmpPrev_reg; // last settled comparator level
  reg cmpPrimed_reg; // set on the first clock after reset
  reg irqEnabled_reg; // global unmask state
  reg irqEnabled_next;
  reg wakeReq_reg;
  reg resumeNext_reg;
  reg vectorReq_reg;
  reg [`WID_VEC_WIDTH-1:0] vectorAddr_reg;
  reg [`WID_VEC_WIDTH-1:0] vectorAddr_next;
  reg vectorHit; // some event vectors this cycle
  reg watchdogResetReq_reg;
  reg peripheralHalt_reg;
  wire cmpChange; // settled comparator edge
  wire cmpSet; // comparator flag set
  wire cmpWake; // comparator wakes the core
  wire cmpVector; // comparator branches
  wire normalMode; // core awake
  wire hpSet; // qualified timer events
  wire lpSet;
  wire auxASet;
  wire auxBSet;
  wire auxCSet;
  wire watchdogFire; // enabled watchdog expired
  wire anyWake; // any wake source fires
  wire flagWipe; // watchdog reset wipes all flags not set in that cycle

  // ************************************************
  // comparator input
  // ************************************************
  // the comparator is analog and asynchronous, so two stages first;
  // the edge is taken only between settled samples
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cmpSync1_reg <= 1'b0;
      cmpSync2_reg <= 1'b0;
      cmpPrev_reg <= 1'b0;
      cmpPrimed_reg <= 1'b0;
    end else begin
      cmpSync1_reg <= comparatorOut;
      cmpSync2_reg <= cmpSync1_reg;
      cmpPrev_reg <= cmpSync2_reg;
      cmpPrimed_reg <= 1'b1; // set on the first clock, two clocks before prev holds a comparator sample
    end
  end

  assign cmpChange = cmpPrimed_reg & (cmpSync2_reg ^ cmpPrev_reg);

  // ************************************************
  // event qualification
  // ************************************************
  assign normalMode = ~sleepMode;

  // flag needs only the irq enable, in either mode
  assign cmpSet = cmpChange & comparatorIrqEnable;

  // wake needs the wake enable; awake cores ignore it
  assign cmpWake = cmpChange & sleepMode & comparatorWakeEnable;

  // vector: asleep only when also woken, awake whenever unmasked
  assign cmpVector = cmpSet & irqEnabled_reg & (normalMode | comparatorWakeEnable);

  // timer sources run only while awake, so sleep gates them out;
  // none of them can wake the core
  assign hpSet = normalMode & highPulseUnderflow & highPulseUnderflowEnable;
  assign lpSet = normalMode & lowPulseUnderflow & lowPulseUnderflowEnable;
  assign auxASet = normalMode & auxTimerAOverflow & auxTimerAIrqEnable;
  assign auxBSet = normalMode & auxTimerBOverflow & auxTimerBIrqEnable;
  assign auxCSet = normalMode & auxTimerCOverflow & auxTimerCIrqEnable;

  // watchdog acts in both modes
  assign watchdogFire = watchdogOn & watchdogTimeout;

  assign anyWake = cmpWake | (sleepMode & watchdogFire);

  // a watchdog reset restarts the device and clears the flags, except one set in that same cycle
  assign flagWipe = watchdogFire;

  // ************************************************
  // pending flags
  // ************************************************
  wid_pending_flag cmpFlag (
    .mclk(mclk),
    .nrst(nrst),
    .setPulse(cmpSet),
    .clearPulse(comparatorFlagClear | flagWipe),
    .flag(comparatorPendingFlag)
  );

  wid_pending_flag hpFlag (
    .mclk(mclk),
    .nrst(nrst),
    .setPulse(hpSet),
    .clearPulse(highPulseFlagClear | flagWipe),
    .flag(highPulseUnderflowFlag)
  );

  wid_pending_flag lpFlag (
    .mclk(mclk),
    .nrst(nrst),
    .setPulse(lpSet),
    .clearPulse(lowPulseFlagClear | flagWipe),
    .flag(lowPulseUnderflowFlag)
  );

  wid_pending_flag auxAFlag (
    .mclk(mclk),
    .nrst(nrst),
    .setPulse(auxASet),
    .clearPulse(auxTimerAFlagClear | flagWipe),
    .flag(auxTimerAOverflowFlag)
  );

  wid_pending_flag auxBFlag (
    .mclk(mclk),
    .nrst(nrst),
    .setPulse(auxBSet),
    .clearPulse(auxTimerBFlagClear | flagWipe),
    .flag(auxTimerBOverflowFlag)
  );

  wid_pending_flag auxCFlag (
    .mclk(mclk),
    .nrst(nrst),
    .setPulse(auxCSet),
    .clearPulse(auxTimerCFlagClear | flagWipe),
    .flag(auxTimerCOverflowFlag)
  );

  // ************************************************
  // global interrupt mask
  // ************************************************
  // mask wins if both ops arrive together; a watchdog reset masks
  always @* begin
    if (watchdogFire | globalIrqMaskOp) begin
      irqEnabled_next = 1'b0;
    end else if (globalIrqUnmaskOp) begin
      irqEnabled_next = 1'b1;
    end else begin
      irqEnabled_next = irqEnabled_reg;
    end
  end

  // ************************************************
  // vector selection
  // ************************************************
  // only the live event vectors, never a stale flag, so a flag left
  // from a masked period cannot branch later; lowest vector wins
  always @* begin
    vectorHit = 1'b1;
    vectorAddr_next = vectorAddr_reg;
    if (watchdogFire) begin
      vectorHit = 1'b0; // reset overrides every branch
    end else if (cmpVector) begin
      vectorAddr_next = `WID_VEC_COMPARATOR;
    end else if (hpSet & irqEnabled_reg) begin
      vectorAddr_next = `WID_VEC_HIGH_PULSE;
    end else if (lpSet & irqEnabled_reg) begin
      vectorAddr_next = `WID_VEC_LOW_PULSE;
    end else if (auxASet & irqEnabled_reg) begin
      vectorAddr_next = `WID_VEC_AUX_A;
    end else if (auxBSet & irqEnabled_reg) begin
      vectorAddr_next = `WID_VEC_AUX_B;
    end else if (auxCSet & irqEnabled_reg) begin
      vectorAddr_next = `WID_VEC_AUX_C;
    end else begin
      vectorHit = 1'b0; // masked or idle: next instruction
    end
  end

  // ************************************************
  // requests to the core
  // ************************************************
  // all requests are one-cycle pulses, one cycle after the event
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      irqEnabled_reg <= `WID_IRQ_ENABLED_RST;
      wakeReq_reg <= 1'b0;
      resumeNext_reg <= 1'b0;
      vectorReq_reg <= 1'b0;
      vectorAddr_reg <= `WID_RESET_ADDR;
      watchdogResetReq_reg <= 1'b0;
      peripheralHalt_reg <= 1'b0;
    end else begin
      irqEnabled_reg <= irqEnabled_next;
      wakeReq_reg <= anyWake;
      // woken with no branch and no reset: carry on in line
      resumeNext_reg <= cmpWake & ~vectorHit & ~watchdogFire;
      vectorReq_reg <= vectorHit;
      if (watchdogFire) begin
        vectorAddr_reg <= `WID_RESET_ADDR;
      end else begin
        vectorAddr_reg <= vectorAddr_next;
      end
      watchdogResetReq_reg <= watchdogFire;
      // clocks stopped from a cycle into sleep to a cycle after it ends, except in the wake pulse cycle
      peripheralHalt_reg <= sleepMode & ~anyWake;
    end
  end

  // ************************************************
  // outputs
  // ************************************************
  assign irqEnabled = irqEnabled_reg;
  assign wakeReq = wakeReq_reg;
  assign resumeNext = resumeNext_reg;
  assign vectorReq = vectorReq_reg;
  assign vectorAddr = vectorAddr_reg;
  assign watchdogResetReq = watchdogResetReq_reg;
  assign peripheralHalt = peripheralHalt_reg;
endmodule

/* bench/wid_assertions.sv */
// concurrent checks on the wake and interrupt dispatch ports
`timescale 1ns/10ps
module wid_assertions (
  input logic mclk, nrst, sleepMode, globalIrqMaskOp, globalIrqUnmaskOp,
  input logic highPulseUnderflowEnable, highPulseUnderflow, highPulseFlagClear,
  input logic auxTimerAIrqEnable, auxTimerAOverflow, watchdogOn, watchdogTimeout,
  input logic highPulseUnderflowFlag, auxTimerAOverflowFlag, irqEnabled, wakeReq,
  input logic resumeNext, vectorReq, watchdogResetReq, peripheralHalt,
  input logic [7:0] vectorAddr
);
  // ********************************
  // properties
  // ********************************
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  // awake and unmasked with no watchdog in the way, so a live event must vector
  wire live = !sleepMode && irqEnabled && !globalIrqMaskOp && !watchdogTimeout;
  wire quiet = !sleepMode && !irqEnabled && !globalIrqUnmaskOp && !watchdogTimeout;
  property p_hp_vec;
    live && highPulseUnderflowEnable && highPulseUnderflow |=> vectorReq && highPulseUnderflowFlag;
  endproperty
  a_hp_vec: assert property (p_hp_vec) else $error("high pulse event did not vector");
  property p_hp_masked;
    quiet && highPulseUnderflowEnable && highPulseUnderflow |=> highPulseUnderflowFlag && !vectorReq;
  endproperty
  a_hp_masked: assert property (p_hp_masked) else $error("masked high pulse wrong");
  property p_a_vec;
    live && auxTimerAIrqEnable && auxTimerAOverflow |=> vectorReq && auxTimerAOverflowFlag;
  endproperty
  a_a_vec: assert property (p_a_vec) else $error("timer A event did not vector");
  property p_a_sleep;
    sleepMode && auxTimerAOverflow && !auxTimerAOverflowFlag |=> !auxTimerAOverflowFlag;
  endproperty
  a_a_sleep: assert property (p_a_sleep) else $error("timer A acted in sleep");
  property p_wdt;
    watchdogOn && watchdogTimeout |=> watchdogResetReq && vectorAddr == 8'h00 && !vectorReq
      && !irqEnabled && (wakeReq || !$past(sleepMode));
  endproperty
  a_wdt: assert property (p_wdt) else $error("watchdog timeout handled wrongly");
  property p_wdt_off;
    !watchdogOn && watchdogTimeout |=> !watchdogResetReq;
  endproperty
  a_wdt_off: assert property (p_wdt_off) else $error("disabled watchdog reset the core");
  property p_halt;
    sleepMode |=> peripheralHalt || wakeReq;
  endproperty
  a_halt: assert property (p_halt) else $error("peripherals ran during sleep");
  property p_mask;
    globalIrqMaskOp |=> !irqEnabled;
  endproperty
  a_mask: assert property (p_mask) else $error("mask op left interrupts open");
  property p_sticky;
    highPulseUnderflowFlag && !highPulseFlagClear && !watchdogTimeout |=> highPulseUnderflowFlag;
  endproperty
  a_sticky: assert property (p_sticky) else $error("pending flag dropped by itself");
  property p_resume;
    resumeNext |-> wakeReq && !vectorReq;
  endproperty
  a_resume: assert property (p_resume) else $error("resume without wake");
  c_vec: cover property (vectorReq);
  c_resume: cover property (wakeReq && resumeNext);
  c_wdt: cover property (watchdogResetReq && wakeReq);
endmodule
bind wake_interrupt_dispatch wid_assertions u_chk (.*);

/* bench/wid_core_model.sv */
// core sequencer model: enters sleep on command, leaves on wake or reset
`timescale 1ns/10ps
module wid_core_model (
  input logic mclk, nrst, wantSleep, slow, wakeReq, watchdogResetReq,
  output logic sleepMode
);
  logic wantPrev; // last sleep command level, to sleep only on a new command
  logic lagWake; // a slow core leaves sleep one cycle late
  // sleep state of the core
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      sleepMode <= 1'h0;
      wantPrev <= 1'h0;
      lagWake <= 1'h0;
    end else begin
      wantPrev <= wantSleep;
      lagWake <= wakeReq && slow;
      if (watchdogResetReq || (wakeReq && !slow) || lagWake || !wantSleep) begin
        sleepMode <= 1'h0;
      end else if (!wantPrev) begin
        sleepMode <= 1'h1;
      end
    end
  end
endmodule

/* bench/tb.sv */
// self-checking bench for the wake and interrupt dispatch block
`timescale 1ns/10ps
`include "wid_consts.vh"
module tb;
  logic mclk = 1'h0, nrst = 1'h0, sleepMode, globalIrqMaskOp = 1'h0, globalIrqUnmaskOp = 1'h0;
  logic comparatorWakeEnable = 1'h0, watchdogOn = 1'h0, comparatorOut = 1'h0;
  logic watchdogTimeout = 1'h0, wantSleep = 1'h0, slow = 1'h0;
  logic irqEnabled, wakeReq, resumeNext, vectorReq, watchdogResetReq, peripheralHalt;
  logic [7:0] vectorAddr, lastVec = 8'h00; // vector address the block should hold
  logic [5:0] en = 6'h00, clr = 6'h00, flags, prevFlags = 6'h00; // cmp hp lp a b c
  logic [4:0] ev = 5'h00; // timer event pulses
  logic [7:0] vecTab [6] = '{`WID_VEC_COMPARATOR, `WID_VEC_HIGH_PULSE, `WID_VEC_LOW_PULSE,
    `WID_VEC_AUX_A, `WID_VEC_AUX_B, `WID_VEC_AUX_C};
  logic [17:0] expQ [$]; // {vector, wake, resume, reset, address, flags}
  int fail_count = 0, total_checks = 0;
  always #50 mclk = ~mclk;
  wid_core_model u_core (.*);
  wake_interrupt_dispatch u_dut (.*,
    .comparatorIrqEnable(en[5]), .highPulseUnderflowEnable(en[4]),
    .lowPulseUnderflowEnable(en[3]), .auxTimerAIrqEnable(en[2]),
    .auxTimerBIrqEnable(en[1]), .auxTimerCIrqEnable(en[0]),
    .highPulseUnderflow(ev[4]), .lowPulseUnderflow(ev[3]), .auxTimerAOverflow(ev[2]),
    .auxTimerBOverflow(ev[1]), .auxTimerCOverflow(ev[0]),
    .comparatorFlagClear(clr[5]), .highPulseFlagClear(clr[4]), .lowPulseFlagClear(clr[3]),
    .auxTimerAFlagClear(clr[2]), .auxTimerBFlagClear(clr[1]), .auxTimerCFlagClear(clr[0]),
    .comparatorPendingFlag(flags[5]), .highPulseUnderflowFlag(flags[4]),
    .lowPulseUnderflowFlag(flags[3]), .auxTimerAOverflowFlag(flags[2]),
    .auxTimerBOverflowFlag(flags[1]), .auxTimerCOverflowFlag(flags[0]));
  // ********************************
  // shared tasks
  // ********************************
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic chk(input string what, input logic [17:0] e, input logic [17:0] g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask
  // one event from source src (0 comparator, 1..5 timers) in a chosen mode
  task automatic run(input int src, input logic s, m, b, w, input logic [5:0] e);
    logic [5:0] f;
    logic v, wk;
    e[5 - src] = b;
    f = 6'h00;
    if (!s || src == 0) f[5 - src] = b; // timers do nothing in sleep
    wk = s && w && src == 0;
    v = b && m && (src == 0 ? (w || !s) : !s);
    if (v) lastVec = vecTab[src];
    if (v || wk || f != 6'h00) expQ.push_back({v, wk, wk && !v, 1'h0, lastVec, f});
    globalIrqMaskOp = !m;
    globalIrqUnmaskOp = m;
    en = e;
    comparatorWakeEnable = w;
    wantSleep = s;
    slow = 1'($urandom);
    cyc(1);
    globalIrqMaskOp = 1'h0;
    globalIrqUnmaskOp = 1'h0;
    cyc(3);
    if (src == 0) comparatorOut = !comparatorOut;
    else ev[5 - src] = 1'h1;
    cyc(1);
    ev = 5'h00;
    cyc(5);
    chk("flags", {12'h000, f}, {12'h000, flags});
    // unmasking with flags still set must not branch
    wantSleep = 1'h0;
    globalIrqUnmaskOp = 1'h1;
    cyc(1);
    globalIrqUnmaskOp = 1'h0;
    cyc(2);
    clr = 6'h3F;
    cyc(1);
    clr = 6'h00;
    cyc(2);
    $display("run src %0d sleep %0d unmasked %0d enabled %0d done", src, s, m, b);
  endtask
  task automatic summarize;
    chk("pending notes", 18'h00000, 18'(expQ.size()));
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // ********************************
  // result monitor: a request pulse or a newly set flag takes the oldest note
  // ********************************
  always @(negedge mclk) begin
    if (nrst && (vectorReq || wakeReq || watchdogResetReq || (flags & ~prevFlags) != 6'h00)) begin
      chk("result", expQ.size() ? expQ.pop_front() : 18'h00000, {vectorReq, wakeReq,
        resumeNext, watchdogResetReq, vectorAddr, flags});
    end
    prevFlags <= flags;
  end
  // hang guard, well beyond the expected run of about 1600 cycles
  initial begin
    #(100 * 20000);
    fail_count++;
    summarize();
  end
  // ********************************
  // main sequence
  // ********************************
  initial begin
    logic b;
    void'($urandom(7));
    cyc(16);
    nrst = 1'h1;
    cyc(4);
    // every source, mode, mask state and enable pair, but for the comparator awake the wake enable follows the irq enable; other enables random
    for (int k = 0; k < 96; k++) begin
      b = k[2];
      run(k / 16, k[0], k[1], b, (k / 16 == 0 && !k[0]) ? b : k[3], 6'($urandom));
    end
    // all timers at once then timer A back to back: one vector per cycle, the first by priority
    globalIrqUnmaskOp = 1'h1;
    en = 6'h1F;
    cyc(1);
    globalIrqUnmaskOp = 1'h0;
    cyc(2);
    expQ.push_back({4'h8, `WID_VEC_HIGH_PULSE, 6'h1F});
    expQ.push_back({4'h8, `WID_VEC_AUX_A, 6'h1F});
    ev = 5'h1F;
    cyc(1);
    ev = 5'h04;
    cyc(1);
    ev = 5'h00;
    cyc(4);
    clr = 6'h3F;
    cyc(1);
    clr = 6'h00;
    cyc(2);
    $display("burst done");
    // watchdog asleep, disabled, then awake
    for (int j = 0; j < 3; j++) begin
      watchdogOn = (j != 1);
      wantSleep = (j == 0);
      cyc(3);
      if (watchdogOn) expQ.push_back({1'h0, wantSleep, 2'h1, `WID_RESET_ADDR, 6'h00});
      watchdogTimeout = 1'h1;
      cyc(1);
      watchdogTimeout = 1'h0;
      cyc(4);
      wantSleep = 1'h0;
      $display("watchdog %0d done", j);
    end
    summarize();
  end
endmodule
